// File: shared/isc_pkg.sv
// Purpose: Shared constants and types for the two-wire slave control port
// Assumes: Register space of 8-bit registers, addresses 00h..30h
// Notes:   Reset values not given elsewhere are plain zero defaults
`default_nettype none

package isc_pkg;

   // Register space
   localparam int         NUM_CH     = 8;
   localparam int         REG_COUNT  = 49;
   localparam logic [7:0] REG_LIMIT  = 8'h31;
   localparam int         REG_CONFA  = 'h00;
   localparam int         REG_MVOL   = 'h07;
   localparam int         REG_CH1VOL = 'h09;

   // Reset values
   localparam logic [7:0] CONFA_RST  = 8'h83;
   localparam logic [7:0] MVOL_RST   = 8'h00;
   localparam logic [7:0] CHVOL_RST  = 8'h00;
   localparam logic [7:0] OTHER_RST  = 8'h00;
   localparam logic [7:0] VOL_FULL   = 8'h00;
   localparam logic [7:0] ATTEN_MAX  = 8'hff;
   localparam logic [7:0] RD_UNMAPPED = 8'h00;

   // Select byte
   localparam logic [6:0] DEV_ADDR_SA0 = 7'h18;
   localparam logic [6:0] DEV_ADDR_SA1 = 7'h19;
   localparam logic       RW_READ      = 1'h1;
   localparam logic [2:0] LAST_BIT     = 3'h7;

   // Synchroniser lanes
   localparam int SYNC_W   = 5;
   localparam int SY_TGL   = 0;
   localparam int SY_SCL   = 1;
   localparam int SY_SDA   = 2;
   localparam int SY_OVR   = 3;
   localparam int SY_STRAP = 4;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RX,
      ST_ACK_SETUP,
      ST_ACK,
      ST_TX,
      ST_MACK,
      ST_IGNORE
   } isc_state_e;

   typedef enum logic [1:0] {
      PH_SEL,
      PH_REG,
      PH_WDATA,
      PH_RDATA
   } isc_phase_e;

   function automatic logic [7:0] isc_reg_default(input int idx);
      logic [7:0] v;
      v = OTHER_RST;
      if (idx == REG_CONFA) begin
         v = CONFA_RST;
      end else if (idx == REG_MVOL) begin
         v = MVOL_RST;
      end else if (idx >= REG_CH1VOL && idx < REG_CH1VOL + NUM_CH) begin
         v = CHVOL_RST;
      end
      return v;
   endfunction

endpackage

`default_nettype wire

// File: src/isc_sync.sv
// Purpose: Two-flop synchroniser for pins entering the core clock domain
// Assumes: Each lane is an independent level
// Notes:   Only the second stage is visible outside
`timescale 1ns/1ps
`default_nettype none

module isc_sync import isc_pkg::*; (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              arst_n,
   // Lanes
   input  wire logic [SYNC_W-1:0] d,
   output logic      [SYNC_W-1:0] q
);

   typedef struct packed {
      logic [SYNC_W-1:0] meta;
      logic [SYNC_W-1:0] stable;
   } isc_sync_s;

   isc_sync_s sync_reg;
   isc_sync_s sync_next;

   always_comb begin
      sync_next        = sync_reg;
      sync_next.meta   = d;
      sync_next.stable = sync_reg.meta;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sync_reg <= '0;
      end else begin
         sync_reg <= sync_next;
      end
   end

   assign q = sync_reg.stable;

endmodule

`default_nettype wire

// File: src/isc_regmem.sv
// Purpose: Internal register space with registered read data
// Assumes: Writes outside the mapped range are dropped
// Notes:   The override input beats any write to master volume
`timescale 1ns/1ps
`default_nettype none

module isc_regmem import isc_pkg::*; (
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   arst_n,
   // Write port
   input  wire logic                   wrEn,
   input  wire logic [7:0]             wrAddr,
   input  wire logic [7:0]             wrData,
   // Read port
   input  wire logic [7:0]             rdAddr,
   output logic      [7:0]             rdData,
   // Override
   input  wire logic                   forceFull,
   // Volume taps
   output logic      [7:0]             mvol,
   output logic      [NUM_CH-1:0][7:0] chVol
);

   typedef struct packed {
      logic [REG_COUNT-1:0][7:0] regs;
      logic [7:0]                rdData;
   } isc_mem_s;

   isc_mem_s mem_reg;
   isc_mem_s mem_next;

   always_comb begin
      mem_next = mem_reg;
      if (wrEn && wrAddr < REG_LIMIT) begin
         mem_next.regs[wrAddr[5:0]] = wrData;
      end
      if (forceFull) begin
         mem_next.regs[REG_MVOL] = VOL_FULL;
      end
      if (rdAddr < REG_LIMIT) begin
         mem_next.rdData = mem_reg.regs[rdAddr[5:0]];
      end else begin
         mem_next.rdData = RD_UNMAPPED;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < REG_COUNT; i++) begin
            mem_reg.regs[i] <= isc_reg_default(i);
         end
         mem_reg.rdData <= '0;
      end else begin
         mem_reg <= mem_next;
      end
   end

   assign rdData = mem_reg.rdData;
   assign mvol   = mem_reg.regs[REG_MVOL];
   assign chVol  = mem_reg.regs[REG_CH1VOL +: NUM_CH];

endmodule

`default_nettype wire

// File: src/isc_i2c_slave_port.sv
// Purpose: Two-wire slave control port into the internal register space
// Assumes: sclClk is the serial clock pin, far slower than core_clk
// Notes:   Protocol sequencing runs on core_clk from synchronised pins;
//          data bits are captured on the serial clock itself
`timescale 1ns/1ps
`default_nettype none

// Function
// - Data falling while clock high is START; device detects it.
// - Data rising while clock high is STOP; device detects it.
// - STOP ends the transaction; device waits for a new START.
// - Each data bit is captured on the rising serial clock edge.
// - Address 0011000 with strap low, 0011001 with strap high.
// - Select byte LSB one means read, zero means write.
// - On address match device acknowledges during the ninth bit.
// - Byte after the select byte is the internal register address.
// - Write: acknowledge select byte, then acknowledge register address.
// - Override pin high forces master volume to 00h, full scale.
// - Master volume offsets each channel volume; channels reset to 0dB.
// - Reset low disables outputs and restores all register defaults.
// - Single write: one data byte acknowledged, then master sends STOP.
// - Multi-byte write starts at any address, runs until STOP.
module isc_i2c_slave_port import isc_pkg::*; (
   // Core clock and reset
   input  wire logic                   core_clk,
   input  wire logic                   arst_n,
   // Two-wire link
   input  wire logic                   sclClk,
   input  wire logic                   sdaIn,
   output logic                        sdaOut,
   output logic                        sdaOe,
   // Control pins
   input  wire logic                   volumeOverridePin,
   input  wire logic                   addressSelectStrap,
   // Towards the audio path
   output logic                        outEnable,
   output logic      [7:0]             masterVol,
   output logic      [NUM_CH-1:0][7:0] chanAtten,
   // Register write report
   output logic                        regWrStrobe,
   output logic      [7:0]             regWrAddr,
   output logic      [7:0]             regWrData,
   // Status
   output logic                        busBusy,
   output logic                        selected
);

   // Link-side state, clocked by the serial clock
   typedef struct packed {
      logic capBit;
      logic bitTgl;
   } isc_link_s;

   // Core-side state
   typedef struct packed {
      isc_state_e                 state;
      isc_phase_e                 phase;
      logic [2:0]                 bitCnt;
      logic [7:0]                 shift;
      logic [7:0]                 txByte;
      logic [7:0]                 ptr;
      logic                       phaseDone;
      logic                       doAck;
      logic                       isRead;
      logic                       sdaDrive;
      logic                       sclPrev;
      logic                       sdaPrev;
      logic                       tglPrev;
      logic                       wrStb;
      logic [7:0]                 wrAddr;
      logic [7:0]                 wrData;
      logic                       busy;
      logic                       sel;
      logic                       outEn;
      logic [NUM_CH-1:0][7:0]     atten;
   } isc_core_s;

   isc_link_s lnk_reg;
   isc_link_s lnk_next;
   isc_core_s core_reg;
   isc_core_s core_next;

   logic [SYNC_W-1:0]      syncIn;
   logic [SYNC_W-1:0]      syncQ;
   logic [7:0]             rdData;
   logic [7:0]             memMvol;
   logic [NUM_CH-1:0][7:0] memChVol;
   logic [NUM_CH-1:0][7:0] attenSum;
   logic                   sclS;
   logic                   sdaS;
   logic                   startEv;
   logic                   stopEv;
   logic                   sclFall;
   logic                   bitEv;
   logic [6:0]             ownAddr;

   // ---- Serial clock domain ----
   // Only one bit and a toggle live here; the core qualifies the bit
   // with the toggle, and the bit is stable for the whole clock high.
   always_comb begin
      lnk_next        = lnk_reg;
      lnk_next.capBit = sdaIn;
      lnk_next.bitTgl = ~lnk_reg.bitTgl;
   end

   always_ff @(posedge sclClk or negedge arst_n) begin
      if (!arst_n) begin
         lnk_reg <= '0;
      end else begin
         lnk_reg <= lnk_next;
      end
   end

   // ---- Crossing into the core domain ----
   always_comb begin
      syncIn           = '0;
      syncIn[SY_TGL]   = lnk_reg.bitTgl;
      syncIn[SY_SCL]   = sclClk;
      syncIn[SY_SDA]   = sdaIn;
      syncIn[SY_OVR]   = volumeOverridePin;
      syncIn[SY_STRAP] = addressSelectStrap;
   end

   isc_sync u_sync (
      .clk    (core_clk),
      .arst_n (arst_n),
      .d      (syncIn),
      .q      (syncQ)
   );

   assign sclS = syncQ[SY_SCL];
   assign sdaS = syncQ[SY_SDA];

   // Both lines pass equal depth, so their relative order is kept
   assign startEv = sclS && core_reg.sclPrev && core_reg.sdaPrev && !sdaS;
   assign stopEv  = sclS && core_reg.sclPrev && !core_reg.sdaPrev && sdaS;
   assign sclFall = core_reg.sclPrev && !sclS;
   assign bitEv   = core_reg.tglPrev != syncQ[SY_TGL];

   assign ownAddr = syncQ[SY_STRAP] ? DEV_ADDR_SA1 : DEV_ADDR_SA0;

   // ---- Volume offset per channel ----
   generate
      for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_atten
         logic [8:0] sum;
         assign sum = {1'b0, memChVol[ch]} + {1'b0, memMvol};
         // Attenuation saturates rather than wrapping to loud
         assign attenSum[ch] = sum[8] ? ATTEN_MAX : sum[7:0];
      end
   endgenerate

   // ---- Protocol sequencing ----
   always_comb begin
      logic [7:0] rxByte;
      rxByte = {core_reg.shift[6:0], lnk_reg.capBit};

      core_next         = core_reg;
      core_next.sclPrev = sclS;
      core_next.sdaPrev = sdaS;
      core_next.tglPrev = syncQ[SY_TGL];
      core_next.wrStb   = 1'b0;
      core_next.outEn   = 1'b1;
      core_next.atten   = attenSum;

      case (core_reg.state)
         ST_IDLE: begin
            core_next.sdaDrive = 1'b0;
         end

         ST_RX: begin
            if (bitEv) begin
               core_next.shift  = rxByte;
               core_next.bitCnt = core_reg.bitCnt + 3'h1;
               if (core_reg.bitCnt == LAST_BIT) begin
                  core_next.state = ST_ACK_SETUP;
                  case (core_reg.phase)
                     PH_SEL: begin
                        core_next.isRead = rxByte[0] == RW_READ;
                        if (rxByte[7:1] == ownAddr) begin
                           core_next.doAck = 1'b1;
                           core_next.sel   = 1'b1;
                        end else begin
                           core_next.doAck = 1'b0;
                           core_next.state = ST_IGNORE;
                        end
                     end
                     PH_REG: begin
                        core_next.ptr   = rxByte;
                        core_next.doAck = 1'b1;
                     end
                     PH_WDATA: begin
                        core_next.wrStb  = 1'b1;
                        core_next.wrAddr = core_reg.ptr;
                        core_next.wrData = rxByte;
                        core_next.ptr    = core_reg.ptr + 8'h01;
                        core_next.doAck  = 1'b1;
                     end
                     default: begin
                        core_next.doAck = 1'b0;
                     end
                  endcase
               end
            end
         end

         // Acknowledge goes out only after the clock has fallen, so the
         // data line never moves while the clock is high
         ST_ACK_SETUP: begin
            if (sclFall) begin
               core_next.sdaDrive  = core_reg.doAck;
               core_next.phaseDone = 1'b0;
               core_next.state     = ST_ACK;
            end
         end

         ST_ACK: begin
            if (bitEv) begin
               core_next.phaseDone = 1'b1;
            end
            if (sclFall && core_reg.phaseDone) begin
               core_next.sdaDrive  = 1'b0;
               core_next.bitCnt    = '0;
               core_next.phaseDone = 1'b0;
               core_next.state     = ST_RX;
               case (core_reg.phase)
                  PH_SEL: begin
                     if (core_reg.isRead) begin
                        core_next.phase    = PH_RDATA;
                        core_next.state    = ST_TX;
                        core_next.txByte   = rdData;
                        core_next.sdaDrive = ~rdData[7];
                        core_next.ptr      = core_reg.ptr + 8'h01;
                     end else begin
                        core_next.phase = PH_REG;
                     end
                  end
                  PH_REG: begin
                     core_next.phase = PH_WDATA;
                  end
                  default: begin
                     core_next.phase = PH_WDATA;
                  end
               endcase
            end
         end

         // Open drain: a zero bit pulls the line, a one releases it
         ST_TX: begin
            if (bitEv) begin
               core_next.bitCnt = core_reg.bitCnt + 3'h1;
               if (core_reg.bitCnt == LAST_BIT) begin
                  core_next.phaseDone = 1'b1;
               end
            end
            if (sclFall) begin
               if (core_reg.phaseDone) begin
                  core_next.sdaDrive  = 1'b0;
                  core_next.phaseDone = 1'b0;
                  core_next.state     = ST_MACK;
               end else begin
                  core_next.sdaDrive = ~core_reg.txByte[~core_reg.bitCnt];
               end
            end
         end

         ST_MACK: begin
            if (bitEv) begin
               core_next.doAck     = ~lnk_reg.capBit;
               core_next.phaseDone = 1'b1;
            end
            if (sclFall && core_reg.phaseDone) begin
               core_next.phaseDone = 1'b0;
               core_next.bitCnt    = '0;
               if (core_reg.doAck) begin
                  core_next.txByte   = rdData;
                  core_next.sdaDrive = ~rdData[7];
                  core_next.ptr      = core_reg.ptr + 8'h01;
                  core_next.state    = ST_TX;
               end else begin
                  core_next.state = ST_IGNORE;
               end
            end
         end

         ST_IGNORE: begin
            core_next.sdaDrive = 1'b0;
         end

         default: begin
            core_next.state    = ST_IDLE;
            core_next.sdaDrive = 1'b0;
         end
      endcase

      // Bus conditions override any byte in progress
      if (startEv) begin
         core_next.state     = ST_RX;
         core_next.phase     = PH_SEL;
         core_next.bitCnt    = '0;
         core_next.sdaDrive  = 1'b0;
         core_next.phaseDone = 1'b0;
         core_next.sel       = 1'b0;
         core_next.busy      = 1'b1;
      end else if (stopEv) begin
         core_next.state     = ST_IDLE;
         core_next.sdaDrive  = 1'b0;
         core_next.sel       = 1'b0;
         core_next.busy      = 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         core_reg <= '0;
      end else begin
         core_reg <= core_next;
      end
   end

   // ---- Register space ----
   isc_regmem u_regmem (
      .clk       (core_clk),
      .arst_n    (arst_n),
      .wrEn      (core_reg.wrStb),
      .wrAddr    (core_reg.wrAddr),
      .wrData    (core_reg.wrData),
      .rdAddr    (core_reg.ptr),
      .rdData    (rdData),
      .forceFull (syncQ[SY_OVR]),
      .mvol      (memMvol),
      .chVol     (memChVol)
   );

   // ---- Outputs ----
   // The clock line is input only; the data line is open drain
   assign sdaOut      = 1'b0;
   assign sdaOe       = core_reg.sdaDrive;
   assign outEnable   = core_reg.outEn;
   assign masterVol   = memMvol;
   assign chanAtten   = core_reg.atten;
   assign regWrStrobe = core_reg.wrStb;
   assign regWrAddr   = core_reg.wrAddr;
   assign regWrData   = core_reg.wrData;
   assign busBusy     = core_reg.busy;
   assign selected    = core_reg.sel;

endmodule

`default_nettype wire

// File: verification/isc_port_sva.sv
// Purpose: Pin-level protocol checks on the two-wire slave port
// Assumes: Serial clock phases are far longer than core_clk
// Notes:   Sees only the top-level ports; bound below
`timescale 1ns/1ps
`default_nettype none

module isc_port_sva import isc_pkg::*; (
   // Core
   input wire logic                   core_clk,
   input wire logic                   arst_n,
   // Link
   input wire logic                   sclClk,
   input wire logic                   sdaIn,
   input wire logic                   sdaOut,
   input wire logic                   sdaOe,
   // Pins
   input wire logic                   volumeOverridePin,
   input wire logic                   addressSelectStrap,
   // Outputs
   input wire logic                   outEnable,
   input wire logic [7:0]             masterVol,
   input wire logic [NUM_CH-1:0][7:0] chanAtten,
   input wire logic                   regWrStrobe,
   input wire logic [7:0]             regWrAddr,
   input wire logic [7:0]             regWrData,
   input wire logic                   busBusy,
   input wire logic                   selected
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   property p_start;
      sclClk && $fell(sdaIn) |-> ##[1:6] busBusy;
   endproperty
   a_start: assert property (p_start)
      else $error("busy did not follow start");

   property p_stop;
      sclClk && $rose(sdaIn) |-> ##[1:6] !busBusy;
   endproperty
   a_stop: assert property (p_stop)
      else $error("busy did not clear after stop");

   property p_oe_edge;
      $changed(sdaOe) |-> !sclClk;
   endproperty
   a_oe_edge: assert property (p_oe_edge)
      else $error("data drive changed while clock high");

   property p_oe_sel;
      sdaOe |-> busBusy && selected;
   endproperty
   a_oe_sel: assert property (p_oe_sel)
      else $error("data driven outside own transaction");

   property p_drive_low;
      sdaOe |-> sdaOut == 1'b0;
   endproperty
   a_drive_low: assert property (p_drive_low)
      else $error("acknowledge does not pull low");

   property p_outen;
      $past(arst_n) |-> outEnable;
   endproperty
   a_outen: assert property (p_outen)
      else $error("outputs not enabled after reset");

   property p_ovr;
      volumeOverridePin [*5] |-> masterVol == 8'h00;
   endproperty
   a_ovr: assert property (p_ovr)
      else $error("override did not force full scale");

   property p_strobe_sel;
      regWrStrobe |-> selected && busBusy;
   endproperty
   a_strobe_sel: assert property (p_strobe_sel)
      else $error("write while not addressed");

   property p_strobe_once;
      regWrStrobe |=> !regWrStrobe;
   endproperty
   a_strobe_once: assert property (p_strobe_once)
      else $error("write strobe longer than one cycle");

   property p_mvol;
      regWrStrobe && regWrAddr == 8'h07 && !volumeOverridePin
         |-> ##[1:3] masterVol == regWrData;
   endproperty
   a_mvol: assert property (p_mvol)
      else $error("master volume write not applied");

   property p_ch1;
      regWrStrobe && regWrAddr == 8'h09 && masterVol == 8'h00
         |-> ##[2:4] chanAtten[0] == regWrData;
   endproperty
   a_ch1: assert property (p_ch1)
      else $error("channel one attenuation wrong");

   c_wr: cover property (regWrStrobe);
   c_ack: cover property ($rose(sdaOe));
   c_ovr: cover property (volumeOverridePin [*5]);
endmodule

bind isc_i2c_slave_port isc_port_sva u_sva (
   .core_clk(core_clk), .arst_n(arst_n), .sclClk(sclClk), .sdaIn(sdaIn),
   .sdaOut(sdaOut), .sdaOe(sdaOe), .volumeOverridePin(volumeOverridePin),
   .addressSelectStrap(addressSelectStrap), .outEnable(outEnable),
   .masterVol(masterVol), .chanAtten(chanAtten), .regWrStrobe(regWrStrobe),
   .regWrAddr(regWrAddr), .regWrData(regWrData), .busBusy(busBusy),
   .selected(selected)
);

`default_nettype wire

// File: verification/isc_master_model.sv
// Purpose: Behavioural two-wire bus master driving the slave port
// Assumes: Open-drain data line with pull-up resolved by the bench
// Notes:   Clock idles high between frames; 32 ns tick, 4 ticks a phase
`timescale 1ns/1ps
`default_nettype none

module isc_master_model (
   // Link
   output logic      sclClk,
   output logic      sdaDrvLow,
   input  wire logic sdaLine
);
   // Long phases keep the core-side synchroniser well clear of edges
   localparam time TQ = 32;

   initial begin
      sclClk = 1'b1;
      sdaDrvLow = 1'b0;
   end

   task automatic bus_start();
      #(2*TQ) sdaDrvLow = 1'b0;
      #(2*TQ) sclClk = 1'b1;
      #(4*TQ) sdaDrvLow = 1'b1;
      #(4*TQ) sclClk = 1'b0;
   endtask

   task automatic put_bit(input logic b, output logic seen);
      #(2*TQ) sdaDrvLow = ~b;
      #(2*TQ) sclClk = 1'b1;
      #(2*TQ) seen = sdaLine;
      #(2*TQ) sclClk = 1'b0;
   endtask

   // Sends d MSB first, then the ninth bit; mAck drives it low
   task automatic xfer(input logic [7:0] d, input logic mAck,
                       output logic [7:0] got, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         put_bit(d[i], s);
         got[i] = s;
      end
      put_bit(~mAck, s);
      ack = ~s;
   endtask

   task automatic bus_stop();
      #(2*TQ) sdaDrvLow = 1'b1;
      #(2*TQ) sclClk = 1'b1;
      #(4*TQ) sdaDrvLow = 1'b0;
      #(4*TQ);
   endtask
endmodule

`default_nettype wire

// File: verification/tb_top.sv
// Purpose: Self-checking bench for the two-wire slave control port
// Assumes: Master model owns the serial clock and its own data drive
// Notes:   Reset, override and strap change 1 ns after the core clock edge
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   import isc_pkg::*;
   logic                   core_clk, arst_n, ovr, strap, scl, mDrv;
   logic                   sdaOut, sdaOe, outEnable, regWrStrobe;
   logic                   busBusy, selected;
   logic [7:0]             masterVol, regWrAddr, regWrData;
   logic [NUM_CH-1:0][7:0] chanAtten;
   int                     failCount, nChecks, nWr, cycN;
   wire                    sdaLine;

   assign sdaLine = ~(mDrv | (sdaOe & ~sdaOut));

   isc_i2c_slave_port dut (
      .core_clk(core_clk), .arst_n(arst_n), .sclClk(scl), .sdaIn(sdaLine),
      .sdaOut(sdaOut), .sdaOe(sdaOe), .volumeOverridePin(ovr),
      .addressSelectStrap(strap), .outEnable(outEnable),
      .masterVol(masterVol), .chanAtten(chanAtten),
      .regWrStrobe(regWrStrobe), .regWrAddr(regWrAddr),
      .regWrData(regWrData), .busBusy(busBusy), .selected(selected)
   );

   isc_master_model mst (
      .sclClk(scl), .sdaDrvLow(mDrv), .sdaLine(sdaLine)
   );

   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   always @(posedge core_clk) begin
      cycN++;
      if (regWrStrobe === 1'b1) nWr++;
      if (cycN == 40000) begin
         failCount++;
         $display("BAD timeout exp %0d got %0d", 0, cycN);
         results();
      end
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   task automatic chk(input string what, input logic [7:0] e,
                      input logic [7:0] g);
      nChecks++;
      if (g !== e) begin
         failCount++;
         $display("BAD %s exp %h got %h", what, e, g);
      end
   endtask

   function automatic logic [7:0] sat(input logic [8:0] s);
      return s[8] ? 8'hff : s[7:0];
   endfunction

   // Whole write frame; acks[i] is the acknowledge of byte i
   task automatic wr(input logic [7:0] b[$], output logic [7:0] acks);
      logic [7:0] g;
      logic       a;
      acks = '0;
      mst.bus_start();
      foreach (b[i]) begin
         mst.xfer(b[i], 1'b0, g, a);
         acks[i] = a;
      end
      mst.bus_stop();
      cyc(8);
   endtask

   task automatic t_reset();
      logic [7:0] e;
      e = sat(9'(CHVOL_RST) + 9'(MVOL_RST));
      chk("outEnable", 8'h01, {7'h0, outEnable});
      chk("masterVol", MVOL_RST, masterVol);
      for (int i = 0; i < NUM_CH; i++) begin
         chk("chanAtten", e, chanAtten[i]);
      end
      chk("sdaOe", 8'h00, {7'h0, sdaOe});
      $display("done t_reset");
   endtask

   task automatic t_single();
      logic [7:0] a;
      int         n0;
      n0 = nWr;
      wr('{8'h30, 8'h09, 8'h12}, a);
      chk("acks", 8'h07, a);
      chk("wrAddr", 8'h09, regWrAddr);
      chk("wrData", 8'h12, regWrData);
      chk("nWr", 8'h01, 8'(nWr - n0));
      chk("ch1", 8'h12, chanAtten[0]);
      chk("busBusy", 8'h00, {7'h0, busBusy});
      $display("done t_single");
   endtask

   task automatic t_multi();
      logic [7:0] a;
      wr('{8'h30, 8'h07, 8'h05, 8'h00, 8'h12, 8'h20}, a);
      chk("acks", 8'h3f, a);
      chk("masterVol", 8'h05, masterVol);
      chk("ch1", sat(9'h12 + 9'h05), chanAtten[0]);
      chk("ch2", sat(9'h20 + 9'h05), chanAtten[1]);
      wr('{8'h30, 8'h0b, 8'hfe}, a);
      chk("ch3", sat(9'hfe + 9'h05), chanAtten[2]);
      $display("done t_multi");
   endtask

   task automatic t_override();
      logic [7:0] a;
      ovr = 1'b1;
      cyc(6);
      chk("masterVol", VOL_FULL, masterVol);
      chk("ch2", 8'h20, chanAtten[1]);
      wr('{8'h30, 8'h07, 8'h33}, a);
      chk("masterVol", VOL_FULL, masterVol);
      ovr = 1'b0;
      cyc(6);
      chk("masterVol", VOL_FULL, masterVol);
      $display("done t_override");
   endtask

   task automatic t_address();
      logic [7:0] a;
      int         n0;
      n0 = nWr;
      wr('{8'h34, 8'h0d, 8'h77}, a);
      chk("acks", 8'h00, a);
      wr('{8'h32, 8'h0d, 8'h77}, a);
      chk("acks", 8'h00, a);
      chk("nWr", 8'h00, 8'(nWr - n0));
      chk("ch5", 8'h00, chanAtten[4]);
      strap = 1'b1;
      cyc(4);
      wr('{8'h32, 8'h0c, 8'h44}, a);
      chk("acks", 8'h07, a);
      chk("ch4", 8'h44, chanAtten[3]);
      wr('{8'h30, 8'h0c, 8'h55}, a);
      chk("acks", 8'h00, a);
      strap = 1'b0;
      cyc(4);
      $display("done t_address");
   endtask

   task automatic t_read();
      logic [7:0] g;
      logic       a0, a1, a2, a3;
      mst.bus_start();
      mst.xfer(8'h30, 1'b0, g, a0);
      mst.xfer(8'h09, 1'b0, g, a1);
      mst.bus_start();
      mst.xfer({DEV_ADDR_SA0, RW_READ}, 1'b0, g, a2);
      mst.xfer(8'hff, 1'b1, g, a3);
      chk("rdData", 8'h12, g);
      mst.xfer(8'hff, 1'b0, g, a3);
      mst.bus_stop();
      cyc(8);
      chk("rdAcks", 8'h07, {5'h0, a2, a1, a0});
      chk("rdNext", 8'h20, g);
      chk("rdNack", 8'h00, {7'h0, a3});
      $display("done t_read");
   endtask

   task automatic t_rerst();
      arst_n = 1'b0;
      cyc(2);
      chk("outEnable", 8'h00, {7'h0, outEnable});
      arst_n = 1'b1;
      cyc(4);
      chk("ch1", CHVOL_RST, chanAtten[0]);
      chk("ch4", CHVOL_RST, chanAtten[3]);
      chk("outEnable", 8'h01, {7'h0, outEnable});
      $display("done t_rerst");
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", nChecks, failCount);
      if (failCount == 0 && nChecks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      arst_n = 1'b0;
      ovr = 1'b0;
      strap = 1'b0;
      cyc(2);
      arst_n = 1'b1;
      cyc(4);
      t_reset();
      t_single();
      t_multi();
      t_read();
      t_override();
      t_address();
      t_rerst();
      results();
   end
endmodule

`default_nettype wire
